// >>> led_matrix_pkg.sv
// package: register map, field layout, reset values and timing of the led matrix control bank
package led_matrix_pkg;

  // ==========================================================================
  // register map
  localparam logic [7:0] ADDR_CONFIG      = 8'h60;
  localparam logic [7:0] ADDR_GLOBAL_CURRENT = 8'h61;
  localparam logic [7:0] ADDR_PULL        = 8'h62;
  localparam logic [7:0] ADDR_SCAN        = 8'h63;
  localparam logic [7:0] ADDR_SPREAD      = 8'h64;
  localparam logic [7:0] ADDR_DETECT      = 8'h65;
  localparam logic [7:0] ADDR_FAULT0      = 8'h66;
  localparam logic [7:0] ADDR_FAULT1      = 8'h67;
  localparam logic [7:0] ADDR_FAULT2      = 8'h68;
  localparam logic [7:0] ADDR_SOFT_RESET  = 8'hdf;
  localparam logic [7:0] ADDR_UPDATE      = 8'hfd;
  localparam logic [7:0] ADDR_PAGE_SEL    = 8'hfe;
  localparam logic [7:0] ADDR_PAGE_UNLOCK = 8'hff;

  // ==========================================================================
  // key values and defaults
  localparam logic [7:0] SOFT_RESET_KEY  = 8'hae;
  localparam logic [7:0] UPDATE_KEY      = 8'h00;
  localparam logic [7:0] PAGE_UNLOCK_KEY = 8'hc5;
  localparam logic [7:0] REG_DEFAULT     = 8'h00;
  localparam logic [1:0] PAGE_CTRL       = 2'd1;

  // ==========================================================================
  // field layout
  typedef struct packed {
    logic [3:0] row_scan_select;
    logic       rsvd;
    logic [1:0] dimming_resolution_sel;
    logic       sw_shutdown_ctl;
  } matrix_config_t;

  typedef struct packed {
    logic       sink_phase_select;
    logic [2:0] row_pulldown_level;
    logic       rsvd;
    logic [2:0] column_pullup_level;
  } pull_select_t;

  typedef struct packed {
    logic       random_scan_enable;
    logic       rsvd6;
    logic [1:0] low_current_mode;
    logic       rsvd3;
    logic [2:0] scan_rate_select;
  } scan_rate_t;

  typedef struct packed {
    logic [2:0] rsvd;
    logic       spread_enable;
    logic [1:0] spread_range;
    logic [1:0] spread_period;
  } spread_t;

  typedef struct packed {
    logic [1:0] detect_type;
    logic [1:0] rsvd;
    logic [3:0] detect_row_select;
  } detect_t;

  // ==========================================================================
  // decoded drive settings for the analog and scan blocks
  typedef struct packed {
    logic        outputs_on;
    logic [11:0] row_enable;
    logic [3:0]  row_group_count;
    logic [2:0]  row_group_size;
    logic [1:0]  dimming_resolution_sel;
    logic [7:0]  global_current_level;
    logic        sink_phase_select;
    logic [2:0]  row_pulldown_level;
    logic [2:0]  column_pullup_level;
    logic        random_scan_active;
    logic        sink_scale_half;
    logic        amp_disable;
    logic [3:0]  scan_rate_shift;
    logic        spread_active;
    logic [1:0]  spread_range;
    logic [1:0]  spread_period;
    logic        detect_enable;
    logic        detect_short;
    logic [3:0]  detect_row_select;
  } drive_t;

  typedef enum logic [1:0] {DET_OFF, DET_OPEN, DET_SHORT} detect_mode_t;

  // ==========================================================================
  // timing
  localparam int unsigned CLK_HZ           = 40_000_000;
  localparam int unsigned SPREAD_PERIOD_US [4] = '{4000, 2200, 1500, 1100};
  localparam int unsigned SCAN_BASE_HZ_62  = 24_000;
  localparam int unsigned SCAN_BASE_HZ_8   = 6_000;
  localparam int unsigned SCAN_BASE_HZ_12  = 400;

  function automatic int unsigned us_to_cycles(input int unsigned us);
    return (CLK_HZ / 1_000_000) * us;
  endfunction

endpackage

// >>> spread_modulator.sv
// spread-spectrum triangle modulator for the scan clock
`timescale 1ns/1ps
module spread_modulator
  import led_matrix_pkg::*;
#(
  parameter int unsigned STEP_BITS = 8
) (
  input  wire logic                 clock,
  input  wire logic                 rst_n,
  input  wire logic                 active,
  input  wire logic [1:0]           period_sel,
  output logic      [STEP_BITS-1:0] offset,
  output logic                      falling
);

  if (STEP_BITS < 2 || STEP_BITS > 16) begin : g_bad_steps
    $error("spread_modulator: bad STEP_BITS");
  end

  typedef struct packed {
    logic [23:0]          tick_cnt;
    logic [STEP_BITS-1:0] offset;
    logic                 falling;
  } mod_state_t;

  mod_state_t s_r, s_nxt;
  logic [23:0] tick_len;

  // one step lasts period / (2 * 2^STEP_BITS)
  always_comb begin
    tick_len = 24'(us_to_cycles(SPREAD_PERIOD_US[period_sel]) >> (STEP_BITS + 1));
    if (tick_len == 24'h000000) tick_len = 24'h000001;
  end

  always_comb begin
    s_nxt = s_r;
    if (!active) begin
      s_nxt = '0;
    end else if (s_r.tick_cnt + 24'h000001 >= tick_len) begin
      s_nxt.tick_cnt = '0;
      if (!s_r.falling) begin
        if (&s_r.offset) s_nxt.falling = 1'b1;
        else s_nxt.offset = s_r.offset + 1'b1;
      end else begin
        if (s_r.offset == '0) s_nxt.falling = 1'b0;
        else s_nxt.offset = s_r.offset - 1'b1;
      end
    end else begin
      s_nxt.tick_cnt = s_r.tick_cnt + 24'h000001;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) s_r <= '0;
    else s_r <= s_nxt;
  end

  assign offset  = s_r.offset;
  assign falling = s_r.falling;

endmodule

// >>> led_matrix_control_registers.sv
// control and status register bank of the led matrix scan driver
`timescale 1ns/1ps
module led_matrix_control_registers
  import led_matrix_pkg::*;
#(
  parameter int unsigned SINKS     = 18,
  parameter int unsigned SPREAD_BITS = 8
) (
  input  wire logic              clock,
  input  wire logic              rst_n,
  input  wire logic              hw_shutdown_pin,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  input  wire logic [7:0]        reg_addr,
  input  wire logic [7:0]        reg_wdata,
  output logic      [7:0]        reg_rdata,
  output logic      [1:0]        page_r_out,
  input  wire logic [SINKS-1:0]  fault_in,
  input  wire logic              fault_valid,
  output drive_t                 drive,
  output logic                   duty_update_pulse,
  output logic      [SPREAD_BITS-1:0] spread_offset
);

  if (SINKS != 18) begin : g_bad_sinks
    $error("led_matrix_control_registers: SINKS must be 18");
  end
  if (SPREAD_BITS < 2 || SPREAD_BITS > 16) begin : g_bad_spread
    $error("led_matrix_control_registers: bad SPREAD_BITS");
  end

  // ==========================================================================
  // state
  typedef struct packed {
    matrix_config_t cfg;
    logic [7:0]     global_current;
    pull_select_t   pull;
    scan_rate_t     scan;
    spread_t        spread;
    detect_t        detect;
    logic [17:0]    fault;
    logic [1:0]     page;
    logic [7:0]     page_unlock_key;
    logic [7:0]     rdata;
    logic           update_pulse;
    drive_t         drive;
    logic [SPREAD_BITS-1:0] spread_q;
  } bank_state_t;

  bank_state_t s_r, s_nxt;
  detect_mode_t det_mode;
  logic         spread_on;
  logic [SPREAD_BITS-1:0] spread_raw;

  function automatic logic [11:0] row_mask(input logic [3:0] code);
    logic [11:0] m;
    m = 12'hfff;
    if (code <= 4'd10) m = 12'hfff >> code;
    else if (code == 4'd12) m = 12'h3ff; // five pairs, top two rows idle
    return m;
  endfunction

  function automatic logic [3:0] row_groups(input logic [3:0] code);
    logic [3:0] g;
    g = 4'd12 - code;
    if (code >= 4'd11) g = 4'd6 - (code - 4'd11);
    return g;
  endfunction

  function automatic logic [2:0] group_size(input logic [3:0] code);
    logic [2:0] z;
    unique case (code)
      4'd11, 4'd12: z = 3'd2;
      4'd13:        z = 3'd3;
      4'd14:        z = 3'd4;
      4'd15:        z = 3'd6;
      default:      z = 3'd1;
    endcase
    return z;
  endfunction

  function automatic logic [7:0] pad6(input logic [5:0] v);
    return {2'b00, v};
  endfunction

  // ==========================================================================
  // detect mode decode
  always_comb begin
    unique case (s_r.detect.detect_type)
      2'b10:   det_mode = DET_OPEN;
      2'b11:   det_mode = DET_SHORT;
      default: det_mode = DET_OFF;
    endcase
  end

  assign spread_on = s_r.spread.spread_enable && (s_r.scan.scan_rate_select <= 3'd3);

  spread_modulator #(
    .STEP_BITS (SPREAD_BITS)
  ) u_spread (
    .clock      (clock),
    .rst_n      (rst_n),
    .active     (spread_on),
    .period_sel (s_r.spread.spread_period),
    .offset     (spread_raw),
    .falling    ()
  );

  // ==========================================================================
  // register access and decode
  always_comb begin
    logic page1;
    page1 = (s_r.page == PAGE_CTRL);
    s_nxt = s_r;
    s_nxt.update_pulse = 1'b0;

    // fault capture while detection runs
    if (det_mode != DET_OFF && fault_valid) s_nxt.fault = fault_in;

    // register reads; write-only and unmapped read zero
    s_nxt.rdata = 8'h00;
    if (reg_rd) begin
      if (reg_addr == ADDR_PAGE_SEL) s_nxt.rdata = {6'h00, s_r.page};
      else if (reg_addr == ADDR_PAGE_UNLOCK) s_nxt.rdata = s_r.page_unlock_key;
      else if (page1) begin
        unique case (reg_addr)
          ADDR_CONFIG: s_nxt.rdata = s_r.cfg;
          ADDR_GLOBAL_CURRENT: s_nxt.rdata = s_r.global_current;
          ADDR_PULL:   s_nxt.rdata = s_r.pull;
          ADDR_SCAN:   s_nxt.rdata = s_r.scan;
          ADDR_SPREAD: s_nxt.rdata = s_r.spread;
          ADDR_DETECT: s_nxt.rdata = s_r.detect;
          ADDR_FAULT0: s_nxt.rdata = pad6(s_r.fault[5:0]);
          ADDR_FAULT1: s_nxt.rdata = pad6(s_r.fault[11:6]);
          ADDR_FAULT2: s_nxt.rdata = pad6(s_r.fault[17:12]);
          default:     s_nxt.rdata = 8'h00;
        endcase
      end
    end

    // register writes; accepted even in hardware shutdown, except the update key write
    if (reg_wr) begin
      if (reg_addr == ADDR_PAGE_UNLOCK) begin
        s_nxt.page_unlock_key = reg_wdata;
      end else if (reg_addr == ADDR_PAGE_SEL) begin
        if (s_r.page_unlock_key == PAGE_UNLOCK_KEY) begin
          s_nxt.page = reg_wdata[1:0];
          s_nxt.page_unlock_key = 8'h00;
        end
      end else if (page1) begin
        unique case (reg_addr)
          ADDR_CONFIG: s_nxt.cfg = matrix_config_t'(reg_wdata & 8'hf7);
          ADDR_GLOBAL_CURRENT: s_nxt.global_current = reg_wdata;
          ADDR_PULL:   s_nxt.pull = pull_select_t'(reg_wdata & 8'hf7);
          ADDR_SCAN:   s_nxt.scan = scan_rate_t'(reg_wdata & 8'hb7);
          ADDR_SPREAD: s_nxt.spread = spread_t'(reg_wdata & 8'h1f);
          ADDR_DETECT: s_nxt.detect = detect_t'(reg_wdata & 8'hcf);
          ADDR_UPDATE: begin
            if (reg_wdata == UPDATE_KEY && hw_shutdown_pin && s_r.cfg.sw_shutdown_ctl)
              s_nxt.update_pulse = 1'b1;
          end
          ADDR_SOFT_RESET: begin
            if (reg_wdata == SOFT_RESET_KEY) begin
              s_nxt.cfg            = '0;
              s_nxt.global_current = REG_DEFAULT;
              s_nxt.pull           = '0;
              s_nxt.scan           = '0;
              s_nxt.spread         = '0;
              s_nxt.detect         = '0;
              s_nxt.fault          = '0;
              s_nxt.page           = '0;
              s_nxt.page_unlock_key = REG_DEFAULT;
            end
          end
          default: ;
        endcase
      end
    end

    // drive decode from registered settings
    s_nxt.drive.outputs_on = s_r.cfg.sw_shutdown_ctl && hw_shutdown_pin;
    s_nxt.drive.row_enable = row_mask(s_r.cfg.row_scan_select);
    s_nxt.drive.row_group_count = row_groups(s_r.cfg.row_scan_select);
    s_nxt.drive.row_group_size = group_size(s_r.cfg.row_scan_select);
    s_nxt.drive.dimming_resolution_sel = s_r.cfg.dimming_resolution_sel;
    s_nxt.drive.global_current_level = s_r.global_current;
    s_nxt.drive.sink_phase_select = s_r.pull.sink_phase_select;
    s_nxt.drive.row_pulldown_level = s_r.pull.row_pulldown_level;
    s_nxt.drive.column_pullup_level = s_r.pull.column_pullup_level;
    s_nxt.drive.random_scan_active = s_r.scan.random_scan_enable &&
      (row_groups(s_r.cfg.row_scan_select) == 4'd12 ||
       row_groups(s_r.cfg.row_scan_select) == 4'd8);
    s_nxt.drive.sink_scale_half = s_r.scan.low_current_mode[0];
    s_nxt.drive.amp_disable = s_r.scan.low_current_mode[1];
    // halving count relative to the mode base rate
    s_nxt.drive.scan_rate_shift = {1'b0, s_r.scan.scan_rate_select};
    s_nxt.drive.spread_active = spread_on;
    s_nxt.drive.spread_range = s_r.spread.spread_range;
    s_nxt.drive.spread_period = s_r.spread.spread_period;
    s_nxt.drive.detect_enable = (det_mode != DET_OFF);
    s_nxt.drive.detect_short = (det_mode == DET_SHORT);
    s_nxt.drive.detect_row_select = s_r.detect.detect_row_select;
    // offset held at zero while idle
    s_nxt.spread_q = spread_on ? spread_raw : '0;
  end

  // ==========================================================================
  // state register
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) s_r <= '0;
    else s_r <= s_nxt;
  end

  // ==========================================================================
  // outputs
  assign reg_rdata         = s_r.rdata;
  assign page_r_out        = s_r.page;
  assign drive             = s_r.drive;
  assign duty_update_pulse = s_r.update_pulse;
  assign spread_offset     = s_r.spread_q;

endmodule

// >>> led_matrix_checker_sva.sv
// assertion checker for the led matrix control register bank
`timescale 1ns/1ps
module led_matrix_checker
  import led_matrix_pkg::*;
#(
  parameter int unsigned SINKS       = 18,
  parameter int unsigned SPREAD_BITS = 8
) (
  input wire logic                   clock,
  input wire logic                   rst_n,
  input wire logic                   hw_shutdown_pin,
  input wire logic                   reg_wr,
  input wire logic                   reg_rd,
  input wire logic [7:0]             reg_addr,
  input wire logic [7:0]             reg_wdata,
  input wire logic [7:0]             reg_rdata,
  input wire logic [1:0]             page_r_out,
  input wire logic [SINKS-1:0]       fault_in,
  input wire logic                   fault_valid,
  input wire drive_t                 drive,
  input wire logic                   duty_update_pulse,
  input wire logic [SPREAD_BITS-1:0] spread_offset
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  // ==========================================================================
  // properties
  property p_pin_blank;
    !hw_shutdown_pin [*3] |-> !drive.outputs_on;
  endproperty
  a_pin_blank: assert property (p_pin_blank) else $error("outputs on with pin low");

  property p_rdata_idle;
    !$past(reg_rd) |-> reg_rdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data without read");

  property p_wo_zero;
    $past(reg_rd && (reg_addr == ADDR_SOFT_RESET || reg_addr == ADDR_UPDATE)) |-> reg_rdata == 8'h00;
  endproperty
  a_wo_zero: assert property (p_wo_zero) else $error("write-only register read nonzero");

  property p_fault_top;
    $past(reg_rd && reg_addr inside {[ADDR_FAULT0:ADDR_FAULT2]}) |-> reg_rdata[7:6] == 2'b00;
  endproperty
  a_fault_top: assert property (p_fault_top) else $error("fault status top bits set");

  property p_update_cause;
    duty_update_pulse |-> $past(reg_wr && reg_addr == ADDR_UPDATE && reg_wdata == UPDATE_KEY
                                && page_r_out == PAGE_CTRL && hw_shutdown_pin);
  endproperty
  a_update_cause: assert property (p_update_cause) else $error("update pulse without write");

  property p_page_unlock;
    (page_r_out != $past(page_r_out)) && page_r_out != 2'd0 |-> $past(reg_wr && reg_addr == ADDR_PAGE_SEL);
  endproperty
  a_page_unlock: assert property (p_page_unlock) else $error("page changed without select");

  property p_rows_contig;
    (drive.row_enable & (drive.row_enable + 12'h001)) == 12'h000;
  endproperty
  a_rows_contig: assert property (p_rows_contig) else $error("row enables not contiguous");

  property p_random_rows;
    drive.random_scan_active |-> drive.row_group_count inside {4'd12, 4'd8};
  endproperty
  a_random_rows: assert property (p_random_rows) else $error("random scan with bad rows");

  property p_spread_idle;
    !drive.spread_active [*3] |-> spread_offset == '0;
  endproperty
  a_spread_idle: assert property (p_spread_idle) else $error("spread offset while idle");

  c_update: cover property (duty_update_pulse);
  c_page:   cover property (page_r_out == PAGE_CTRL);
  c_fault:  cover property (fault_valid && drive.detect_enable);
endmodule

bind led_matrix_control_registers led_matrix_checker #(.SINKS(SINKS), .SPREAD_BITS(SPREAD_BITS)) u_chk (
  .clock(clock), .rst_n(rst_n), .hw_shutdown_pin(hw_shutdown_pin), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .page_r_out(page_r_out), .fault_in(fault_in), .fault_valid(fault_valid), .drive(drive),
  .duty_update_pulse(duty_update_pulse), .spread_offset(spread_offset));

// >>> host_bus_model.sv
// host-side model: issues register writes and reads at the falling edge
`timescale 1ns/1ps
module host_bus_model (
  input  wire logic       clock,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic [7:0]      reg_addr,
  output logic [7:0]      reg_wdata,
  input  wire logic [7:0] reg_rdata
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clock);
    reg_wr = 1'b0;
    // released bus carries no stale value
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask

  task rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clock);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clock);
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rdata;
  endtask
endmodule

// >>> led_matrix_control_registers_tb.sv
// testbench for the led matrix control register bank
`timescale 1ns/1ps
module led_matrix_control_registers_tb;
  import led_matrix_pkg::*;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic        hw_shutdown_pin = 1'b1;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic [7:0]  reg_rdata;
  logic [1:0]  page_r_out;
  logic [17:0] fault_in = 18'h00000;
  logic        fault_valid = 1'b0;
  drive_t      drive;
  logic        duty_update_pulse;
  logic [7:0]  spread_offset;
  logic [7:0]  d;
  int          miscompares = 0;
  int          n_tests = 0;
  int          cycles = 0;
  int          pulses = 0;
  int          exp_pulses = 0;
  int          page = 0;
  int          unlocked = 0;
  int          m [256];

  always #12.5 clock = ~clock;

  led_matrix_control_registers #(.SINKS(18), .SPREAD_BITS(8)) dut (
    .clock(clock), .rst_n(rst_n), .hw_shutdown_pin(hw_shutdown_pin), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .page_r_out(page_r_out), .fault_in(fault_in), .fault_valid(fault_valid), .drive(drive),
    .duty_update_pulse(duty_update_pulse), .spread_offset(spread_offset));

  host_bus_model host (.clock(clock), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
                       .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

  task final_report;
    if (miscompares == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  always @(negedge clock) begin
    cycles++;
    if (duty_update_pulse === 1'b1) pulses++;
    if (cycles == 20000) begin
      miscompares++;
      final_report();
    end
  end

  task chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // writable bits of each control register, zero for read-only places
  function automatic int msk(input int a);
    case (a)
      8'h60, 8'h62: return 8'hf7;
      8'h61: return 8'hff;
      8'h63: return 8'hb7;
      8'h64: return 8'h1f;
      8'h65: return 8'hcf;
      default: return 0;
    endcase
  endfunction

  // ==========================================================================
  // bus tasks with reference model
  task w(input int a, input int v);
    host.wr(a[7:0], v[7:0]);
    if (page == 1 && msk(a) != 0) m[a] = v & msk(a);
    if (page == 1 && a == 8'hfd && v == 0 && hw_shutdown_pin && m[8'h60][0]) exp_pulses++;
    if (page == 1 && a == 8'hdf && v == 8'hae) begin
      m = '{default: 0};
      page = 0;
      unlocked = 0;
    end
    if (a == 8'hfe && unlocked == 1) page = v & 3;
    unlocked = (a == 8'hff) ? (v == 8'hc5) : ((a == 8'hfe) ? 0 : unlocked);
  endtask

  task r(input int a);
    host.rd(a[7:0], d);
    chk(d, (page == 1 && a >= 8'h60 && a <= 8'h68) ? m[a] : 0);
  endtask

  task dchk;
    int c;
    int g;
    int sz;
    c = m[8'h60] >> 4;
    g = (c <= 10) ? 12 - c : 17 - c;
    sz = (c <= 10) ? 1 : 12 / g;
    chk(drive.outputs_on, m[8'h60] & 1 & hw_shutdown_pin);
    chk(drive.row_enable, (1 << (g * sz)) - 1);
    chk({drive.row_group_count, drive.row_group_size}, {g[3:0], sz[2:0]});
    chk(drive.dimming_resolution_sel, (m[8'h60] >> 1) & 3);
    chk(drive.global_current_level, m[8'h61]);
    chk({drive.sink_phase_select, drive.row_pulldown_level, drive.column_pullup_level},
        {m[8'h62][7:4], m[8'h62][2:0]});
    chk({drive.amp_disable, drive.sink_scale_half}, m[8'h63][5:4]);
    chk(drive.random_scan_active, m[8'h63][7] && (g == 12 || g == 8));
    chk(drive.scan_rate_shift, m[8'h63][2:0]);
    chk({drive.spread_active, drive.spread_range, drive.spread_period},
        {m[8'h64][4] && m[8'h63][2:0] < 4, m[8'h64][3:0]});
    chk({drive.detect_enable, drive.detect_short, drive.detect_row_select},
        {m[8'h65][7], m[8'h65][7] & m[8'h65][6], m[8'h65][3:0]});
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    void'($urandom(32'h729f37d1));
    m = '{default: 0};
    repeat (8) @(negedge clock);
    rst_n = 1'b1;
    r(8'h60);
    w(8'hfe, 1);
    chk(page_r_out, 0);
    w(8'hff, 8'hc5);
    w(8'hfe, 1);
    chk(page_r_out, 1);
    for (int a = 8'h5f; a <= 8'h69; a++) r(a);
    r(8'hdf);
    r(8'hfd);
    dchk();
    for (int i = 0; i < 120; i++) begin
      hw_shutdown_pin = ($urandom % 4) != 0;
      repeat (4) @(negedge clock);
      if (i < 16) w(8'h60, (i << 4) | ($urandom % 16));
      else w(8'h60 + $urandom % 7, $urandom % 256);
      repeat (2) @(negedge clock);
      dchk();
      r(8'h60 + i % 9);
    end
    for (int t = 0; t < 4; t++) begin
      w(8'h65, t << 6);
      fault_in = 18'($urandom);
      fault_valid = 1'b1;
      @(negedge clock);
      fault_valid = 1'b0;
      if (t >= 2) begin
        m[8'h66] = fault_in[5:0];
        m[8'h67] = fault_in[11:6];
        m[8'h68] = fault_in[17:12];
      end
      for (int a = 8'h66; a <= 8'h68; a++) r(a);
    end
    // spread from a clean start, shortest period, then an excluded scan rate
    w(8'h63, 0);
    w(8'h64, 0);
    w(8'h64, 8'h13);
    repeat (200) @(negedge clock);
    chk(spread_offset inside {[8'h01:8'h03]}, 1);
    dchk();
    w(8'h63, 4);
    repeat (3) @(negedge clock);
    chk(spread_offset, 0);
    dchk();
    for (int k = 0; k < 4; k++) begin
      hw_shutdown_pin = (k != 3);
      repeat (4) @(negedge clock);
      w(8'h60, k != 2);
      w(8'hfd, k == 1);
    end
    repeat (2) @(negedge clock);
    chk(pulses, exp_pulses);
    w(8'h61, 8'hff);
    w(8'hdf, 8'h12);
    r(8'h61);
    w(8'hdf, 8'hae);
    chk(page_r_out, 0);
    w(8'hff, 8'hc5);
    w(8'hfe, 1);
    for (int a = 8'h60; a <= 8'h68; a++) r(a);
    dchk();
    final_report();
  end
endmodule
